// *** inc/cirq_consts.svh ***
// offsets, field positions, reset values and timing counts of the irq/wake/bus-off block
// assumes inclusion by bare name from the design and testbench files
`ifndef CIRQ_CONSTS_SVH
`define CIRQ_CONSTS_SVH

// ==========================================================
// register word offsets (byte addresses, wishbone 32-bit)
`define CIRQ_ADDR_CTRL0     8'h00
`define CIRQ_ADDR_CTRL1     8'h04
`define CIRQ_ADDR_RXFLAG    8'h08
`define CIRQ_ADDR_RXIEN     8'h0c
`define CIRQ_ADDR_TXFLAG    8'h10
`define CIRQ_ADDR_TXIEN     8'h14
`define CIRQ_ADDR_MISC      8'h18

// ==========================================================
// control_reg_zero fields
`define CIRQ_C0_INIT_REQUEST      0
`define CIRQ_C0_SLEEP_REQUEST       1
`define CIRQ_C0_WAKE_ON_BUS_ENABLE        2
// control_reg_one fields
`define CIRQ_C1_INIT_ACKNOWLEDGE      0
`define CIRQ_C1_SLEEP_ACKNOWLEDGE       1
`define CIRQ_C1_WAKE_FILTER_SELECT        2
`define CIRQ_C1_BUSOFF_RECOVERY_MODE        3
`define CIRQ_C1_MODULE_ENABLE        7
// rx_flag_reg fields
`define CIRQ_RF_RXF         0
`define CIRQ_RF_RX_OVERRUN_FLAG       1
`define CIRQ_RF_TX_STATE_FIELD_LO    2
`define CIRQ_RF_RX_STATE_FIELD_LO    4
`define CIRQ_RF_STATUS_CHANGE_FLAG       6
`define CIRQ_RF_WAKE_EVENT_FLAG       7
// rx_irq_enable_reg fields
`define CIRQ_RE_RX_FULL_IRQ_ENABLE       0
`define CIRQ_RE_RX_OVERRUN_IRQ_ENABLE       1
`define CIRQ_RE_STATUS_CHANGE_IRQ_ENABLE       6
`define CIRQ_RE_WAKE_IRQ_ENABLE       7
// misc_reg fields
`define CIRQ_MI_BUSOFF_HOLD      0

// ==========================================================
// reset values
`define CIRQ_RST_CTRL0      8'h01
`define CIRQ_RST_CTRL1      8'h01
`define CIRQ_RST_RXIEN      8'h00
`define CIRQ_RST_TXIEN      3'h0
`define CIRQ_RST_TXE        3'h7

// ==========================================================
// timing: bit time and counts
`define CIRQ_CLK_MHZ        100
`define CIRQ_BIT_NS         2000
`define CIRQ_BIT_CYC        ((`CIRQ_BIT_NS * `CIRQ_CLK_MHZ) / 1000)
`define CIRQ_IDLE_BITS      11
`define CIRQ_BUSOFF_SEQ     128
`define CIRQ_WAKE_FILT_NS   500
`define CIRQ_WAKE_FILT_CYC  ((`CIRQ_WAKE_FILT_NS * `CIRQ_CLK_MHZ + 999) / 1000)

`endif

// *** inc/cirq_pkg.sv ***
// types shared by the irq/wake/bus-off block
// assumes cirq_consts.svh on the include path
package cirq_pkg;

  // ==========================================================
  // operating mode of the controller
  typedef enum logic [4:0] {
    CIRQ_INIT   = 5'h01,
    CIRQ_NORMAL = 5'h02,
    CIRQ_SLEEP  = 5'h04,
    CIRQ_RESYNC = 5'h08,
    CIRQ_BUSOFF = 5'h10
  } cirq_mode_t;

  // fault confinement range of one error counter
  typedef enum logic [1:0] {
    CIRQ_ST_OK      = 2'h0,
    CIRQ_ST_WARN    = 2'h1,
    CIRQ_ST_PASSIVE = 2'h2,
    CIRQ_ST_BUSOFF  = 2'h3
  } cirq_errst_t;

endpackage

// *** verilog/cirq_wake_filter.sv ***
// glitch filter on the receive line for wake-up detection
// assumes rx input synchronous to clk_i; dominant = 0
`timescale 1ns/1ps
`include "cirq_consts.svh"

module cirq_wake_filter (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic filter_en_i,
  input  wire logic rx_i,
  output logic      wake_o
);

  localparam int unsigned FCYC = `CIRQ_WAKE_FILT_CYC;

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        wake_reg;
  logic        wake_next;

  // ==========================================================
  // dominant width count
  always_comb begin
    cnt_next  = 16'h0000;
    wake_next = 1'b0;
    if (!rx_i) begin
      if (cnt_reg < FCYC[15:0]) begin
        cnt_next = cnt_reg + 16'h0001;
      end else begin
        cnt_next = cnt_reg;
      end
      // short pulses rejected only when the filter is selected
      wake_next = filter_en_i ? (cnt_reg + 16'h0001 >= FCYC[15:0]) : 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg  <= 16'h0000;
      wake_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      wake_reg <= wake_next;
    end
  end

  assign wake_o = wake_reg;

endmodule // cirq_wake_filter

// *** verilog/cirq_ctrl.sv ***
// interrupt, wake-up and bus-off recovery logic of a can controller
// assumes a classic wishbone master, a core that reports rx/tx events,
// receive pin synchronous to clk_i
//
// Operation
// - wake enabled: leave sleep on bus activity
// - filter select low-passes receive line in sleep
// - four requests, local enables, cpu mask
// - error irq from status change, overrun
// - tx irq when any buffer empty
// - rx full set after end of frame
// - rx full re-set for next fifo message
// - sleep bus activity sets wake flag
// - error irq on overrun or state entry
// - status change flag, tx/rx state fields
// - request holds while enabled flag set
// - flags clear by writing one only
// - clear ignored while condition persists
// - stop wake only if slept, enabled
// - auto recovery after 128 idle sequences
// - user recovery needs sequences and hold clear
// - after wake wait 11 recessive bits
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "cirq_consts.svh"

module cirq_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cpu_irq_mask_i,
  input  wire logic        power_down_i,
  input  wire logic        can_receive_pin,
  input  wire logic        rx_eof_ok_i,
  input  wire logic        rx_fifo_pending_i,
  input  wire logic        rx_overrun_i,
  input  wire logic [2:0]  tx_done_i,
  input  wire logic        core_idle_i,
  input  wire logic [1:0]  tx_state_i,
  input  wire logic [1:0]  rx_state_i,
  output logic             rx_shift_o,
  output logic             core_active_o,
  output logic             wake_irq_o,
  output logic             err_irq_o,
  output logic             rx_irq_o,
  output logic             tx_irq_o
);

  localparam int unsigned BITC = `CIRQ_BIT_CYC;

  // ==========================================================
  // field pack / update helper
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] clr, input logic [7:0] hold);
    // set wins over clear; a held condition blocks the clear
    w1c = set | (cur & ~(clr & ~hold));
  endfunction

  function automatic logic idle_bit(input logic [15:0] c);
    idle_bit = (c == BITC[15:0] - 16'h0001);
  endfunction

  // ==========================================================
  // state
  cirq_pkg::cirq_mode_t mode_reg, mode_next;
  logic [7:0]  ctrl0_reg, ctrl0_next;
  logic [7:0]  ctrl1_reg, ctrl1_next;
  logic [7:0]  rflg_reg, rflg_next;
  logic [7:0]  rien_reg, rien_next;
  logic [2:0]  txe_reg, txe_next;
  logic [2:0]  tien_reg, tien_next;
  logic        hold_reg, hold_next;
  logic [15:0] bitc_reg, bitc_next;
  logic [3:0]  rec_reg, rec_next;
  logic [7:0]  seq_reg, seq_next;
  logic        seqdone_reg, seqdone_next;
  logic        slept_reg, slept_next;
  logic [31:0] dat_reg, dat_next;
  logic        ack_reg, ack_next;

  logic        wake_raw;
  logic        wr, rd_sel;
  logic        bit_tick, idle_seq;
  logic [7:0]  rclr, rset, rhold;
  logic        busoff_now;

  cirq_wake_filter u_filter (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .filter_en_i (ctrl1_reg[`CIRQ_C1_WAKE_FILTER_SELECT]),
    .rx_i        (can_receive_pin),
    .wake_o      (wake_raw)
  );

  assign wr         = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg & wb_sel_i[0];
  assign rd_sel     = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign busoff_now = (tx_state_i == cirq_pkg::CIRQ_ST_BUSOFF);

  // ==========================================================
  // recessive bit / idle sequence counting
  always_comb begin
    bit_tick  = idle_bit(bitc_reg);
    bitc_next = (bit_tick || !can_receive_pin) ? 16'h0000 : bitc_reg + 16'h0001;
    idle_seq  = 1'b0;
    rec_next  = rec_reg;
    if (!can_receive_pin) begin
      rec_next = 4'h0;
    end else if (bit_tick) begin
      if (rec_reg == 4'(`CIRQ_IDLE_BITS - 1)) begin
        rec_next = 4'h0;
        idle_seq = 1'b1;
      end else begin
        rec_next = rec_reg + 4'h1;
      end
    end
  end

  // ==========================================================
  // mode machine and flags
  always_comb begin
    mode_next    = mode_reg;
    ctrl0_next   = ctrl0_reg;
    ctrl1_next   = ctrl1_reg;
    rien_next    = rien_reg;
    tien_next    = tien_reg;
    hold_next    = hold_reg;
    seq_next     = seq_reg;
    seqdone_next = seqdone_reg;
    slept_next   = slept_reg;
    rclr         = 8'h00;
    rset         = 8'h00;
    rhold        = 8'h00;
    rx_shift_o   = 1'b0;

    // cpu writes to control and enables
    if (wr) begin
      unique case (wb_adr_i)
        `CIRQ_ADDR_CTRL0: begin
          ctrl0_next[`CIRQ_C0_WAKE_ON_BUS_ENABLE] = wb_dat_i[`CIRQ_C0_WAKE_ON_BUS_ENABLE];
          // requests cannot be withdrawn before acknowledged
          if (wb_dat_i[`CIRQ_C0_INIT_REQUEST] || ctrl1_reg[`CIRQ_C1_INIT_ACKNOWLEDGE]) begin
            ctrl0_next[`CIRQ_C0_INIT_REQUEST] = wb_dat_i[`CIRQ_C0_INIT_REQUEST];
          end
          if (wb_dat_i[`CIRQ_C0_SLEEP_REQUEST] || ctrl1_reg[`CIRQ_C1_SLEEP_ACKNOWLEDGE]) begin
            ctrl0_next[`CIRQ_C0_SLEEP_REQUEST] = wb_dat_i[`CIRQ_C0_SLEEP_REQUEST];
          end
        end
        `CIRQ_ADDR_CTRL1: begin
          ctrl1_next[`CIRQ_C1_MODULE_ENABLE] = wb_dat_i[`CIRQ_C1_MODULE_ENABLE];
          if (mode_reg == cirq_pkg::CIRQ_INIT) begin
            ctrl1_next[`CIRQ_C1_WAKE_FILTER_SELECT] = wb_dat_i[`CIRQ_C1_WAKE_FILTER_SELECT];
            ctrl1_next[`CIRQ_C1_BUSOFF_RECOVERY_MODE] = wb_dat_i[`CIRQ_C1_BUSOFF_RECOVERY_MODE];
          end
        end
        `CIRQ_ADDR_RXFLAG: rclr = wb_dat_i[7:0];
        `CIRQ_ADDR_RXIEN:  rien_next = wb_dat_i[7:0] & 8'hc3;
        `CIRQ_ADDR_TXIEN:  tien_next = wb_dat_i[2:0];
        `CIRQ_ADDR_MISC: begin
          // only a clear is meaningful; hold is set by entering bus-off with user recovery mode selected
          if (wb_dat_i[`CIRQ_MI_BUSOFF_HOLD]) begin
            hold_next = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // status change on range entry, fields record the new states
    if ((tx_state_i != rflg_reg[3:2]) || (rx_state_i != rflg_reg[5:4])) begin
      if (tx_state_i != cirq_pkg::CIRQ_ST_OK || rx_state_i != cirq_pkg::CIRQ_ST_OK) begin
        rset[`CIRQ_RF_STATUS_CHANGE_FLAG] = 1'b1;
      end
    end
    if (rx_overrun_i) begin
      rset[`CIRQ_RF_RX_OVERRUN_FLAG] = 1'b1;
    end
    rhold[`CIRQ_RF_RX_OVERRUN_FLAG] = rx_overrun_i;
    rhold[`CIRQ_RF_STATUS_CHANGE_FLAG] = rset[`CIRQ_RF_STATUS_CHANGE_FLAG];

    unique case (mode_reg)
      cirq_pkg::CIRQ_INIT: begin
        if (!ctrl0_reg[`CIRQ_C0_INIT_REQUEST] && ctrl1_reg[`CIRQ_C1_MODULE_ENABLE]) begin
          mode_next = cirq_pkg::CIRQ_NORMAL;
          ctrl1_next[`CIRQ_C1_INIT_ACKNOWLEDGE] = 1'b0;
        end else begin
          ctrl1_next[`CIRQ_C1_INIT_ACKNOWLEDGE] = 1'b1;
        end
      end
      cirq_pkg::CIRQ_NORMAL: begin
        if (ctrl0_reg[`CIRQ_C0_INIT_REQUEST]) begin
          mode_next = cirq_pkg::CIRQ_INIT;
        end else if (busoff_now) begin
          mode_next = cirq_pkg::CIRQ_BUSOFF;
          seq_next = 8'h00;
          seqdone_next = 1'b0;
          hold_next = ctrl1_reg[`CIRQ_C1_BUSOFF_RECOVERY_MODE];
        end else if (ctrl0_reg[`CIRQ_C0_SLEEP_REQUEST] && core_idle_i) begin
          mode_next = cirq_pkg::CIRQ_SLEEP;
          ctrl1_next[`CIRQ_C1_SLEEP_ACKNOWLEDGE] = 1'b1;
        end else if (rx_eof_ok_i || (rx_fifo_pending_i && !rflg_reg[`CIRQ_RF_RXF])) begin
          // move into foreground buffer, flag full
          rx_shift_o = 1'b1;
          rset[`CIRQ_RF_RXF] = 1'b1;
        end
      end
      cirq_pkg::CIRQ_SLEEP: begin
        // wake enable masks the bus; filter decides activity
        if (ctrl0_reg[`CIRQ_C0_WAKE_ON_BUS_ENABLE] && wake_raw) begin
          mode_next = cirq_pkg::CIRQ_RESYNC;
          rset[`CIRQ_RF_WAKE_EVENT_FLAG] = 1'b1;
          ctrl0_next[`CIRQ_C0_SLEEP_REQUEST] = 1'b0;
          ctrl1_next[`CIRQ_C1_SLEEP_ACKNOWLEDGE] = 1'b0;
        end else if (!ctrl0_reg[`CIRQ_C0_SLEEP_REQUEST]) begin
          mode_next = cirq_pkg::CIRQ_RESYNC;
          ctrl1_next[`CIRQ_C1_SLEEP_ACKNOWLEDGE] = 1'b0;
        end else if (ctrl0_reg[`CIRQ_C0_INIT_REQUEST]) begin
          mode_next = cirq_pkg::CIRQ_INIT;
        end
      end
      cirq_pkg::CIRQ_RESYNC: begin
        // frame that woke us is dropped while waiting for idle
        if (idle_seq) begin
          mode_next = cirq_pkg::CIRQ_NORMAL;
        end
      end
      cirq_pkg::CIRQ_BUSOFF: begin
        if (idle_seq && seq_reg != 8'(`CIRQ_BUSOFF_SEQ - 1) && !seqdone_reg) begin
          seq_next = seq_reg + 8'h01;
        end else if (idle_seq) begin
          seqdone_next = 1'b1;
        end
        // either order: count finished and hold released
        if (seqdone_reg && (!ctrl1_reg[`CIRQ_C1_BUSOFF_RECOVERY_MODE] || !hold_reg)) begin
          mode_next = cirq_pkg::CIRQ_NORMAL;
        end else if (ctrl0_reg[`CIRQ_C0_INIT_REQUEST]) begin
          mode_next = cirq_pkg::CIRQ_INIT;
        end
      end
    endcase

    // remember sleep before power down for stop recovery
    slept_next = power_down_i ? slept_reg : (mode_reg == cirq_pkg::CIRQ_SLEEP);

    if (mode_next == cirq_pkg::CIRQ_INIT && mode_reg != cirq_pkg::CIRQ_INIT) begin
      rien_next = `CIRQ_RST_RXIEN;
      tien_next = `CIRQ_RST_TXIEN;
      ctrl0_next[`CIRQ_C0_SLEEP_REQUEST] = 1'b0;
      ctrl0_next[`CIRQ_C0_WAKE_ON_BUS_ENABLE] = 1'b0;
      ctrl1_next[`CIRQ_C1_SLEEP_ACKNOWLEDGE] = 1'b0;
    end

    rflg_next = w1c(rflg_reg, rset, rclr & 8'hc3, rhold);
    rflg_next[3:2] = tx_state_i;
    rflg_next[5:4] = rx_state_i;
    // empty flags: hw sets on completion, sw clears to schedule
    txe_next = tx_done_i | (txe_reg & ~((wr && wb_adr_i == `CIRQ_ADDR_TXFLAG) ? wb_dat_i[2:0] : 3'h0));
    if (mode_reg == cirq_pkg::CIRQ_INIT) begin
      rflg_next = 8'h00;
      txe_next  = `CIRQ_RST_TXE;
    end
  end

  // ==========================================================
  // bus slave read path, single wait-free ack
  always_comb begin
    ack_next = rd_sel;
    dat_next = dat_reg;
    if (rd_sel && !wb_we_i) begin
      unique case (wb_adr_i)
        `CIRQ_ADDR_CTRL0:  dat_next = {24'h0, ctrl0_reg};
        `CIRQ_ADDR_CTRL1:  dat_next = {24'h0, ctrl1_reg};
        `CIRQ_ADDR_RXFLAG: dat_next = {24'h0, rflg_reg};
        `CIRQ_ADDR_RXIEN:  dat_next = {24'h0, rien_reg};
        `CIRQ_ADDR_TXFLAG: dat_next = {29'h0, txe_reg};
        `CIRQ_ADDR_TXIEN:  dat_next = {29'h0, tien_reg};
        `CIRQ_ADDR_MISC:   dat_next = {31'h0, hold_reg};
        default:           dat_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg    <= cirq_pkg::CIRQ_INIT;
      ctrl0_reg   <= `CIRQ_RST_CTRL0;
      ctrl1_reg   <= `CIRQ_RST_CTRL1;
      rflg_reg    <= 8'h00;
      rien_reg    <= `CIRQ_RST_RXIEN;
      txe_reg     <= `CIRQ_RST_TXE;
      tien_reg    <= `CIRQ_RST_TXIEN;
      hold_reg    <= 1'b0;
      bitc_reg    <= 16'h0000;
      rec_reg     <= 4'h0;
      seq_reg     <= 8'h00;
      seqdone_reg <= 1'b0;
      slept_reg   <= 1'b0;
      dat_reg     <= 32'h0;
      ack_reg     <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      ctrl0_reg   <= ctrl0_next;
      ctrl1_reg   <= ctrl1_next;
      rflg_reg    <= rflg_next;
      rien_reg    <= rien_next;
      txe_reg     <= txe_next;
      tien_reg    <= tien_next;
      hold_reg    <= hold_next;
      bitc_reg    <= bitc_next;
      rec_reg     <= rec_next;
      seq_reg     <= seq_next;
      seqdone_reg <= seqdone_next;
      slept_reg   <= slept_next;
      dat_reg     <= dat_next;
      ack_reg     <= ack_next;
    end
  end

  // ==========================================================
  // interrupt requests, combinational and gated by cpu mask
  always_comb begin
    // during power down a wake fires only if the block slept before; err/rx/tx are not gated
    wake_irq_o = ~cpu_irq_mask_i & rflg_reg[`CIRQ_RF_WAKE_EVENT_FLAG] & rien_reg[`CIRQ_RE_WAKE_IRQ_ENABLE]
                 & ctrl0_reg[`CIRQ_C0_WAKE_ON_BUS_ENABLE] & (~power_down_i | slept_reg);
    err_irq_o  = ~cpu_irq_mask_i & ((rflg_reg[`CIRQ_RF_STATUS_CHANGE_FLAG] & rien_reg[`CIRQ_RE_STATUS_CHANGE_IRQ_ENABLE])
                 | (rflg_reg[`CIRQ_RF_RX_OVERRUN_FLAG] & rien_reg[`CIRQ_RE_RX_OVERRUN_IRQ_ENABLE]));
    rx_irq_o   = ~cpu_irq_mask_i & rflg_reg[`CIRQ_RF_RXF] & rien_reg[`CIRQ_RE_RX_FULL_IRQ_ENABLE];
    tx_irq_o   = ~cpu_irq_mask_i & (|(txe_reg & tien_reg));
  end

  assign core_active_o = (mode_reg == cirq_pkg::CIRQ_NORMAL);
  assign wb_dat_o      = dat_reg;
  assign wb_ack_o      = ack_reg;

endmodule // cirq_ctrl

// *** tb/cirq_bus_node.sv ***
// model of another can node: holds the bus recessive, drives dominant pulses
// assumes go_i/len_i driven synchronously to clk_i
`timescale 1ns/1ps

module cirq_bus_node (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  output logic            rx_o
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  // ==========================================================
  // pulse length counter
  always_comb begin
    cnt_next = cnt_reg;
    if (go_i) begin
      cnt_next = len_i;
    end else if (cnt_reg != 8'h00) begin
      cnt_next = cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    cnt_reg <= rst_i ? 8'h00 : cnt_next;
  end

  // released bus floats back to recessive
  assign rx_o = (cnt_reg == 8'h00);
endmodule // cirq_bus_node

// *** tb/cirq_ctrl_checker.sv ***
// port-level checks of the irq/wake/bus-off block
// assumes classic wishbone master and the enable layout of cirq_consts.svh
`timescale 1ns/1ps
`include "cirq_consts.svh"

module cirq_ctrl_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        cpu_irq_mask_i,
  input wire logic        rx_eof_ok_i,
  input wire logic        rx_overrun_i,
  input wire logic [2:0]  tx_done_i,
  input wire logic        core_active_o,
  input wire logic        wake_irq_o,
  input wire logic        err_irq_o,
  input wire logic        rx_irq_o,
  input wire logic        tx_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // shadow of the enable registers, taken when a write is accepted
  logic [2:0] tien_reg, tien_next;
  logic [7:0] rien_reg, rien_next;
  logic       wr_take;
  assign wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  always_comb begin
    tien_next = tien_reg;
    rien_next = rien_reg;
    if (wr_take && wb_adr_i == `CIRQ_ADDR_TXIEN) tien_next = wb_dat_i[2:0];
    if (wr_take && wb_adr_i == `CIRQ_ADDR_RXIEN) rien_next = wb_dat_i[7:0];
  end
  always_ff @(posedge clk_i) begin
    tien_reg <= rst_i ? 3'h0 : tien_next;
    rien_reg <= rst_i ? 8'h00 : rien_next;
  end

  // ==========================================================
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_woke;
    $rose(wake_irq_o);
  endsequence

  a_ack_one_cycle: assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_dat_on_read: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i) else $error("read data moved");
  a_irq_cpu_mask: assert property (cpu_irq_mask_i |-> !(wake_irq_o || err_irq_o || rx_irq_o || tx_irq_o))
    else $error("irq while masked");
  a_tx_irq_gate: assert property (tien_reg == 3'h0 |-> !tx_irq_o) else $error("tx irq not enabled");
  a_tx_done_irq: assert property ((tx_done_i & tien_reg) != 3'h0 |=> tx_irq_o || cpu_irq_mask_i)
    else $error("tx irq missing");
  a_rx_full_irq: assert property (rx_eof_ok_i && rien_reg[0] && core_active_o |=> rx_irq_o || cpu_irq_mask_i)
    else $error("rx irq missing");
  a_overrun_err: assert property (rx_overrun_i && rien_reg[1] |=> err_irq_o || cpu_irq_mask_i)
    else $error("overrun irq missing");
  a_wake_in_sleep: assert property (s_woke |-> !core_active_o) else $error("wake outside sleep");
  a_wake_resync: assert property (s_woke |=> !core_active_o [*8]) else $error("active right after wake");
endmodule // cirq_ctrl_checker

bind cirq_ctrl cirq_ctrl_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cpu_irq_mask_i(cpu_irq_mask_i), .rx_eof_ok_i(rx_eof_ok_i),
  .rx_overrun_i(rx_overrun_i), .tx_done_i(tx_done_i), .core_active_o(core_active_o),
  .wake_irq_o(wake_irq_o), .err_irq_o(err_irq_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o)
);

// *** tb/test_cirq_ctrl.sv ***
// self-checking bench of the irq/wake/bus-off block
// assumes cirq_consts.svh on the include path, one 100 mhz clock
`timescale 1ns/1ps
`include "cirq_consts.svh"

module test_cirq_ctrl;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mask, eof, pend, ovr, go, rxp;
  int          shifts;
  logic [7:0]  wb_adr_i, plen;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [2:0]  txd;
  logic [1:0]  tst, rst_st;
  logic        rx_shift_o, core_active_o, wake_irq_o, err_irq_o, rx_irq_o, tx_irq_o;
  int          failures, checks_done, n;

  cirq_ctrl u_cirq_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cpu_irq_mask_i(mask), .power_down_i(1'b0), .can_receive_pin(rxp),
    .rx_eof_ok_i(eof), .rx_fifo_pending_i(pend), .rx_overrun_i(ovr), .tx_done_i(txd),
    .core_idle_i(1'b1), .tx_state_i(tst), .rx_state_i(rst_st), .rx_shift_o(rx_shift_o),
    .core_active_o(core_active_o), .wake_irq_o(wake_irq_o), .err_irq_o(err_irq_o),
    .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));
  cirq_bus_node u_cirq_bus_node (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .len_i(plen), .rx_o(rxp));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // count shifts so each scenario can see its own, not an earlier frame's
  always @(posedge clk_i) if (rx_shift_o === 1'b1) shifts <= shifts + 1;

  // ==========================================================
  // helpers
  task automatic print_verdict;
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= adr; wb_dat_i <= {24'h0, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin failures++; print_verdict(); end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00);
    chk(q, {24'h0, exp});
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // bounded wait for normal mode; returns the cycles it took
  task automatic wait_active(output int c);
    c = 0;
    while (core_active_o !== 1'b1 && c < 5000) begin @(posedge clk_i); c++; end
    if (c >= 5000) begin failures++; print_verdict(); end
  endtask
  task automatic pulse(input logic [7:0] w);
    @(posedge clk_i); go <= 1'b1; plen <= w;
    @(posedge clk_i); go <= 1'b0;
    repeat (w) @(posedge clk_i);
    settle();
  endtask

  // ==========================================================
  initial begin
    int c;
    {wb_cyc_i, wb_stb_i, wb_we_i, mask, eof, pend, ovr, go} = '0;
    shifts = 0;
    wb_adr_i = 8'h00; wb_dat_i = 32'h0; plen = 8'h00; txd = 3'h0; tst = 2'h0; rst_st = 2'h0;
    failures = 0; checks_done = 0; rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`CIRQ_ADDR_CTRL0, `CIRQ_RST_CTRL0);
    rd(`CIRQ_ADDR_CTRL1, `CIRQ_RST_CTRL1);
    rd(`CIRQ_ADDR_RXIEN, `CIRQ_RST_RXIEN);
    rd(`CIRQ_ADDR_TXIEN, {5'h0, `CIRQ_RST_TXIEN});
    rd(`CIRQ_ADDR_TXFLAG, {5'h0, `CIRQ_RST_TXE});
    wb(1'b1, 8'h1c, 8'hff);
    rd(8'h1c, 8'h00);
    // enable, pick filtered wake in init, then leave init
    wb(1'b1, `CIRQ_ADDR_CTRL1, 8'h84);
    wb(1'b1, `CIRQ_ADDR_CTRL0, 8'h00);
    wait_active(c);
    rd(`CIRQ_ADDR_CTRL1, 8'h84);
    // transmit group
    wb(1'b1, `CIRQ_ADDR_TXIEN, 8'h07);
    settle(); chk(tx_irq_o, 1);
    @(posedge clk_i); mask <= 1'b1; settle(); chk(tx_irq_o, 0);
    @(posedge clk_i); mask <= 1'b0;
    wb(1'b1, `CIRQ_ADDR_TXFLAG, 8'h00); rd(`CIRQ_ADDR_TXFLAG, 8'h07);
    wb(1'b1, `CIRQ_ADDR_TXFLAG, 8'h01); rd(`CIRQ_ADDR_TXFLAG, 8'h06);
    settle(); chk(tx_irq_o, 1);
    wb(1'b1, `CIRQ_ADDR_TXFLAG, 8'h06); settle(); chk(tx_irq_o, 0);
    @(posedge clk_i); txd <= 3'h2;
    @(posedge clk_i); txd <= 3'h0;
    settle(); chk(tx_irq_o, 1);
    rd(`CIRQ_ADDR_TXFLAG, 8'h02);
    // receive group
    wb(1'b1, `CIRQ_ADDR_RXIEN, 8'hc3);
    @(posedge clk_i); eof <= 1'b1;
    @(posedge clk_i); eof <= 1'b0;
    settle(); chk(rx_irq_o, 1);
    wb(1'b1, `CIRQ_ADDR_RXFLAG, 8'h00); rd(`CIRQ_ADDR_RXFLAG, 8'h01);
    pend <= 1'b1;
    c = shifts;
    wb(1'b1, `CIRQ_ADDR_RXFLAG, 8'h01); settle();
    chk(shifts - c, 1);
    rd(`CIRQ_ADDR_RXFLAG, 8'h01);
    pend <= 1'b0;
    wb(1'b1, `CIRQ_ADDR_RXFLAG, 8'h01); settle(); chk(rx_irq_o, 0);
    // error group: overrun, then state changes
    @(posedge clk_i); ovr <= 1'b1; settle(); chk(err_irq_o, 1);
    wb(1'b1, `CIRQ_ADDR_RXFLAG, 8'h02); rd(`CIRQ_ADDR_RXFLAG, 8'h02);
    ovr <= 1'b0;
    wb(1'b1, `CIRQ_ADDR_RXFLAG, 8'h02); rd(`CIRQ_ADDR_RXFLAG, 8'h00);
    tst <= 2'h1; rst_st <= 2'h2; settle(); chk(err_irq_o, 1);
    rd(`CIRQ_ADDR_RXFLAG, 8'h64);
    wb(1'b1, `CIRQ_ADDR_RXFLAG, 8'h40); rd(`CIRQ_ADDR_RXFLAG, 8'h24);
    settle(); chk(err_irq_o, 0);
    // sleep with wake armed first, glitch ignored, long pulse wakes
    wb(1'b1, `CIRQ_ADDR_CTRL0, 8'h04);
    wb(1'b1, `CIRQ_ADDR_CTRL0, 8'h06);
    c = 0;
    do begin rd(`CIRQ_ADDR_CTRL1, 8'h86); c++; end while (q[1] !== 1'b1 && c < 20);
    pulse(8'd20);
    rd(`CIRQ_ADDR_RXFLAG, 8'h24);
    chk(core_active_o, 0);
    pulse(8'd120);
    chk(wake_irq_o, 1);
    rd(`CIRQ_ADDR_RXFLAG, 8'ha4);
    wait_active(c);
    chk(c >= (`CIRQ_IDLE_BITS - 1) * `CIRQ_BIT_CYC, 1);
    wb(1'b1, `CIRQ_ADDR_RXFLAG, 8'h80); settle(); chk(wake_irq_o, 0);
    print_verdict();
  end
endmodule // test_cirq_ctrl
